// file: wsf_cfg.svh
// Constants for the word-shift and queue engine and its scan sequencer
`ifndef WSF_CFG_SVH
`define WSF_CFG_SVH
`define WSF_WORD_W 16
`define WSF_ADDR_W 10
`define WSF_MEM_WORDS 1024
`define WSF_LEN_W 10
`define WSF_SHIFT_LEN_MIN 10'h001
`define WSF_LEN_MAX 10'h200
`define WSF_QUEUE_LEN_MIN 10'h002
`define WSF_ABUS_W 8
`define WSF_REG_CTRL 8'h00
`define WSF_REG_SRC 8'h04
`define WSF_REG_DST 8'h08
`define WSF_REG_LEN 8'h0C
`define WSF_REG_STEP 8'h10
`define WSF_REG_SCAN 8'h14
`define WSF_REG_MADDR 8'h18
`define WSF_REG_MDATA 8'h1C
`define WSF_REG_STATUS 8'h20
`define WSF_REG_INTST 8'h24
`define WSF_REG_INTMASK 8'h28
`define WSF_CTRL_OP_LSB 0
`define WSF_CTRL_CONT_BIT 2
`define WSF_CTRL_COND_BIT 3
`define WSF_ST_BUSY_BIT 0
`define WSF_ST_CARRY_BIT 1
`define WSF_ST_ZERO_BIT 2
`define WSF_ST_ERR_BIT 3
`define WSF_INT_DONE_BIT 0
`define WSF_INT_CARRY_BIT 1
`define WSF_INT_ZERO_BIT 2
`define WSF_INT_ERR_BIT 3
`define WSF_INT_W 4
`define WSF_CTRL_RST 32'h00000000
`endif

// file: wsf_pkg.sv
// Types shared by the engine and the sequencer
package wsf_pkg;
  typedef enum logic [1:0] {
    OP_WORD_SHIFT_RIGHT,
    OP_WORD_SHIFT_LEFT,
    OP_QUEUE_WRITE,
    OP_QUEUE_READ
  } wsf_op_t;
endpackage : wsf_pkg

// file: wsf_if.sv
// Link between the scan sequencer and the word-shift engine
`timescale 1ns/1ns
`include "wsf_cfg.svh"
interface wsf_if;
  logic scan;
  logic cond;
  logic cont;
  wsf_pkg::wsf_op_t op;
  logic [`WSF_ADDR_W-1:0] srcAddr;
  logic [`WSF_ADDR_W-1:0] dstAddr;
  logic [`WSF_LEN_W-1:0] bufferLength;
  logic [`WSF_LEN_W-1:0] shiftStep;
  logic memWe;
  logic [`WSF_ADDR_W-1:0] memAddr;
  logic [`WSF_WORD_W-1:0] memWdata;
  logic [`WSF_WORD_W-1:0] memRdata;
  logic busy;
  logic done;
  logic carryFlag;
  logic zeroFlag;
  logic paramErr;
  modport dev (
    input scan, cond, cont, op, srcAddr, dstAddr, bufferLength, shiftStep,
    input memWe, memAddr, memWdata,
    output memRdata, busy, done, carryFlag, zeroFlag, paramErr
  );
  modport seq (
    output scan, cond, cont, op, srcAddr, dstAddr, bufferLength, shiftStep,
    output memWe, memAddr, memWdata,
    input memRdata, busy, done, carryFlag, zeroFlag, paramErr
  );
endinterface : wsf_if

// file: wsf_device.sv
// Word-shift and queue engine with its own word memory
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "wsf_cfg.svh"

// Functional notes
// - Word shift length 1 to 512 words
// - Shift step 1 up to buffer length
// - Shift by step, refill vacated words from source
// - Shift once per condition edge, or every scan
// - Grouped bit operands use equal digit counts
// - Queue write length 2 to 512, pointer first
// - Program clears queue pointer before first write
// - Write source after last entry, pointer plus one
// - Pointer at limit blocks write, sets carry
// - Queue read length 2 to 512, pointer first
// - Read oldest entry to destination, pointer minus one
// - Remaining entries move down, last slot kept
// - Pointer zero blocks read, sets zero flag
// - Continuous read does one read per scan
module wsf_device (
  input wire clk,
  input wire nrst,
  wsf_if.dev lnk
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_MOVE1,
    ST_MOVE2,
    ST_PTR,
    ST_DONE
  } wsf_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Word memory, 16-bit words
  logic [`WSF_WORD_W-1:0] mem [0:`WSF_MEM_WORDS-1];

  wsf_state_t state_q;
  wsf_pkg::wsf_op_t op_q;
  logic condPrev_q;
  logic busy_q;
  logic done_q;
  logic carry_q;
  logic zero_q;
  logic paramErr_q;
  logic [`WSF_WORD_W-1:0] rdData_q;
  logic [`WSF_ADDR_W-1:0] rd_q;
  logic [`WSF_ADDR_W-1:0] wr_q;
  logic [`WSF_LEN_W-1:0] cnt_q;
  logic dec_q;
  logic [`WSF_ADDR_W-1:0] rd2_q;
  logic [`WSF_ADDR_W-1:0] wr2_q;
  logic [`WSF_LEN_W-1:0] cnt2_q;
  logic [`WSF_ADDR_W-1:0] ptrAddr_q;
  logic [`WSF_WORD_W-1:0] ptrNew_q;
  logic [`WSF_WORD_W-1:0] ptrWord;
  logic fire;
  logic legal;
  logic isQueue;
  logic qwFull;
  logic memWe;
  logic [`WSF_ADDR_W-1:0] memWa;
  logic [`WSF_WORD_W-1:0] memWd;

  function automatic logic [`WSF_ADDR_W-1:0] addrOff(
    input logic [`WSF_ADDR_W-1:0] base,
    input logic [`WSF_ADDR_W-1:0] off
  );
    addrOff = base + off;
  endfunction : addrOff

  function automatic logic paramsOk(
    input wsf_pkg::wsf_op_t op,
    input logic [`WSF_LEN_W-1:0] len,
    input logic [`WSF_LEN_W-1:0] step
  );
    logic ok;
    ok = 1'b0;
    unique case (op)
      wsf_pkg::OP_WORD_SHIFT_RIGHT, wsf_pkg::OP_WORD_SHIFT_LEFT:
        ok = (len >= `WSF_SHIFT_LEN_MIN) && (len <= `WSF_LEN_MAX)
          && (step >= `WSF_SHIFT_LEN_MIN) && (step <= len);
      wsf_pkg::OP_QUEUE_WRITE, wsf_pkg::OP_QUEUE_READ:
        ok = (len >= `WSF_QUEUE_LEN_MIN) && (len <= `WSF_LEN_MAX);
    endcase
    paramsOk = ok;
  endfunction : paramsOk

  ////////////////////////////////////////////////////////////////////////////////
  // Edge trigger, or every scan when continuous
  assign fire = lnk.scan && !busy_q && lnk.cond && (lnk.cont || !condPrev_q);
  assign legal = paramsOk(lnk.op, lnk.bufferLength, lnk.shiftStep);
  assign isQueue = (op_q == wsf_pkg::OP_QUEUE_WRITE) || (op_q == wsf_pkg::OP_QUEUE_READ);
  assign ptrWord = mem[ptrAddr_q];
  // No free slot once pointer reaches length minus one
  assign qwFull = {6'h00, ptrWord[`WSF_ADDR_W-1:0]} >= 16'(lnk.bufferLength - 10'h001)
    || (ptrWord[`WSF_WORD_W-1:`WSF_ADDR_W] != 6'h00);

  // Condition history only advances on scans the engine accepts
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      condPrev_q <= 1'b0;
    else if (lnk.scan && !busy_q)
      condPrev_q <= lnk.cond;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer of the memory moves
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      op_q <= wsf_pkg::OP_WORD_SHIFT_RIGHT;
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
      dec_q <= 1'b0;
      rd2_q <= '0;
      wr2_q <= '0;
      cnt2_q <= '0;
      ptrAddr_q <= '0;
      ptrNew_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (fire && legal)
          begin
            op_q <= lnk.op;
            dec_q <= 1'b0;
            rd2_q <= lnk.srcAddr;
            cnt2_q <= lnk.shiftStep;
            cnt_q <= lnk.bufferLength - lnk.shiftStep;
            unique case (lnk.op)
              // Right: move down by step, fill top from source
              wsf_pkg::OP_WORD_SHIFT_RIGHT:
              begin
                rd_q <= addrOff(lnk.dstAddr, lnk.shiftStep);
                wr_q <= lnk.dstAddr;
                wr2_q <= addrOff(lnk.dstAddr, lnk.bufferLength - lnk.shiftStep);
                state_q <= ST_MOVE1;
              end
              // Left: move up from the top, fill bottom from source
              wsf_pkg::OP_WORD_SHIFT_LEFT:
              begin
                rd_q <= addrOff(lnk.dstAddr, lnk.bufferLength - lnk.shiftStep - 10'h001);
                wr_q <= addrOff(lnk.dstAddr, lnk.bufferLength - 10'h001);
                dec_q <= 1'b1;
                wr2_q <= lnk.dstAddr;
                state_q <= ST_MOVE1;
              end
              wsf_pkg::OP_QUEUE_WRITE:
              begin
                ptrAddr_q <= lnk.dstAddr;
                state_q <= ST_CHECK;
              end
              wsf_pkg::OP_QUEUE_READ:
              begin
                ptrAddr_q <= lnk.srcAddr;
                state_q <= ST_CHECK;
              end
            endcase
          end
        ST_CHECK:
          if (op_q == wsf_pkg::OP_QUEUE_WRITE)
          begin
            // Full queue ends with nothing written
            if (qwFull)
              state_q <= ST_DONE;
            else
            begin
              // Source into slot after last entry
              rd_q <= rd2_q;
              wr_q <= addrOff(addrOff(ptrAddr_q, ptrWord[`WSF_ADDR_W-1:0]), 10'h001);
              cnt_q <= 10'h001;
              cnt2_q <= '0;
              ptrNew_q <= ptrWord + 16'h0001;
              state_q <= ST_MOVE1;
            end
          end
          else
          begin
            // Empty queue ends with nothing read
            if (ptrWord == 16'h0000)
              state_q <= ST_DONE;
            else
            begin
              rd_q <= addrOff(ptrAddr_q, 10'h001);
              wr_q <= wr2_q;
              cnt_q <= 10'h001;
              // Shift the rest down, last slot untouched
              rd2_q <= addrOff(ptrAddr_q, 10'h002);
              wr2_q <= addrOff(ptrAddr_q, 10'h001);
              cnt2_q <= cnt2_q - 10'h002;
              ptrNew_q <= ptrWord - 16'h0001;
              state_q <= ST_MOVE1;
            end
          end
        ST_MOVE1, ST_MOVE2:
          if (cnt_q == '0)
          begin
            if (state_q == ST_MOVE1)
            begin
              rd_q <= rd2_q;
              wr_q <= wr2_q;
              cnt_q <= cnt2_q;
              dec_q <= 1'b0;
              state_q <= ST_MOVE2;
            end
            else
              state_q <= isQueue ? ST_PTR : ST_DONE;
          end
          else
          begin
            rd_q <= dec_q ? rd_q - 10'h001 : rd_q + 10'h001;
            wr_q <= dec_q ? wr_q - 10'h001 : wr_q + 10'h001;
            cnt_q <= cnt_q - 10'h001;
          end
        ST_PTR:
          state_q <= ST_DONE;
        ST_DONE:
          state_q <= ST_IDLE;
      endcase
      // Queue read keeps destination in wr2 until the check
      if (state_q == ST_IDLE && fire && legal && lnk.op == wsf_pkg::OP_QUEUE_READ)
      begin
        wr2_q <= lnk.dstAddr;
        cnt2_q <= lnk.bufferLength;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Single write port; sequencer access only while idle
  always_comb
  begin
    memWe = 1'b0;
    memWa = lnk.memAddr;
    memWd = lnk.memWdata;
    if ((state_q == ST_MOVE1 || state_q == ST_MOVE2) && cnt_q != '0)
    begin
      memWe = 1'b1;
      memWa = wr_q;
      memWd = mem[rd_q];
    end
    else if (state_q == ST_PTR)
    begin
      memWe = 1'b1;
      memWa = ptrAddr_q;
      memWd = ptrNew_q;
    end
    else if (state_q == ST_IDLE && !busy_q)
      memWe = lnk.memWe;
  end

  always_ff @(posedge clk)
  begin
    if (memWe)
      mem[memWa] <= memWd;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdData_q <= '0;
    else
      rdData_q <= mem[lnk.memAddr];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Busy, done and result flags
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      paramErr_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == ST_DONE) || (state_q == ST_IDLE && fire && !legal);
      if (state_q == ST_IDLE && fire)
      begin
        busy_q <= legal;
        paramErr_q <= !legal;
      end
      else if (state_q == ST_DONE)
        busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (state_q == ST_CHECK)
    begin
      // Flags report the latest queue outcome
      if (op_q == wsf_pkg::OP_QUEUE_WRITE)
        carry_q <= qwFull;
      else
        zero_q <= (ptrWord == 16'h0000);
    end
  end

  assign lnk.memRdata = rdData_q;
  assign lnk.busy = busy_q;
  assign lnk.done = done_q;
  assign lnk.carryFlag = carry_q;
  assign lnk.zeroFlag = zero_q;
  assign lnk.paramErr = paramErr_q;

endmodule : wsf_device

// file: wsf_host.sv
// Scan sequencer: APB registers that issue operations to the engine
`timescale 1ns/1ns
`include "wsf_cfg.svh"
module wsf_host (
  input wire clk,
  input wire nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`WSF_ABUS_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  wsf_if.seq lnk
);

  logic [31:0] ctrl_q;
  logic [`WSF_ADDR_W-1:0] src_q;
  logic [`WSF_ADDR_W-1:0] dst_q;
  logic [`WSF_LEN_W-1:0] len_q;
  logic [`WSF_LEN_W-1:0] step_q;
  logic [`WSF_ADDR_W-1:0] maddr_q;
  logic [`WSF_WORD_W-1:0] mdata_q;
  logic memWe_q;
  logic scanPend_q;
  logic scan_q;
  logic [`WSF_INT_W-1:0] intSt_q;
  logic [`WSF_INT_W-1:0] intMask_q;
  logic [`WSF_INT_W-1:0] intSet;
  logic setup;
  logic wr;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // APB: answer in the first access cycle
  assign setup = psel && !penable;
  // Writes land on the access edge that samples pready, not on setup
  assign wr = psel && penable && pready && pwrite;
  assign mapped = paddr inside {`WSF_REG_CTRL, `WSF_REG_SRC, `WSF_REG_DST, `WSF_REG_LEN,
    `WSF_REG_STEP, `WSF_REG_SCAN, `WSF_REG_MADDR, `WSF_REG_MDATA, `WSF_REG_STATUS,
    `WSF_REG_INTST, `WSF_REG_INTMASK};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= '0;
      if (setup && !pwrite)
        unique case (paddr)
          `WSF_REG_CTRL: prdata <= ctrl_q;
          `WSF_REG_SRC: prdata <= {22'h000000, src_q};
          `WSF_REG_DST: prdata <= {22'h000000, dst_q};
          `WSF_REG_LEN: prdata <= {22'h000000, len_q};
          `WSF_REG_STEP: prdata <= {22'h000000, step_q};
          `WSF_REG_MADDR: prdata <= {22'h000000, maddr_q};
          `WSF_REG_MDATA: prdata <= {16'h0000, lnk.memRdata};
          `WSF_REG_STATUS: prdata <= {28'h0000000, lnk.paramErr, lnk.zeroFlag,
            lnk.carryFlag, lnk.busy};
          `WSF_REG_INTST: prdata <= {28'h0000000, intSt_q};
          `WSF_REG_INTMASK: prdata <= {28'h0000000, intMask_q};
          default: prdata <= '0;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operation set-up registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= `WSF_CTRL_RST;
      src_q <= '0;
      dst_q <= '0;
      len_q <= '0;
      step_q <= '0;
      maddr_q <= '0;
    end
    else if (wr)
      unique case (paddr)
        `WSF_REG_CTRL: ctrl_q <= {28'h0000000, pwdata[3:0]};
        `WSF_REG_SRC: src_q <= pwdata[`WSF_ADDR_W-1:0];
        `WSF_REG_DST: dst_q <= pwdata[`WSF_ADDR_W-1:0];
        `WSF_REG_LEN: len_q <= pwdata[`WSF_LEN_W-1:0];
        `WSF_REG_STEP: step_q <= pwdata[`WSF_LEN_W-1:0];
        `WSF_REG_MADDR: maddr_q <= pwdata[`WSF_ADDR_W-1:0];
        default: ;
      endcase
  end

  // Memory writes are dropped by the engine while it is busy
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      memWe_q <= 1'b0;
      mdata_q <= '0;
    end
    else
    begin
      memWe_q <= wr && paddr == `WSF_REG_MDATA;
      if (wr && paddr == `WSF_REG_MDATA)
        mdata_q <= pwdata[`WSF_WORD_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scan request waits until the engine is free
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scanPend_q <= 1'b0;
      scan_q <= 1'b0;
    end
    else
    begin
      scan_q <= scanPend_q && !lnk.busy && !scan_q;
      if (wr && paddr == `WSF_REG_SCAN)
        scanPend_q <= 1'b1;
      else if (scanPend_q && !lnk.busy && !scan_q)
        scanPend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear; set wins
  assign intSet = {lnk.done && lnk.paramErr, lnk.done && lnk.zeroFlag,
    lnk.done && lnk.carryFlag, lnk.done};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      intSt_q <= '0;
      intMask_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `WSF_REG_INTST)
        intSt_q <= (intSt_q & ~pwdata[`WSF_INT_W-1:0]) | intSet;
      else
        intSt_q <= intSt_q | intSet;
      if (wr && paddr == `WSF_REG_INTMASK)
        intMask_q <= pwdata[`WSF_INT_W-1:0];
      irq <= |(intSt_q & intMask_q);
    end
  end

  assign lnk.scan = scan_q;
  assign lnk.cond = ctrl_q[`WSF_CTRL_COND_BIT];
  assign lnk.cont = ctrl_q[`WSF_CTRL_CONT_BIT];
  assign lnk.op = wsf_pkg::wsf_op_t'(ctrl_q[`WSF_CTRL_OP_LSB+1:`WSF_CTRL_OP_LSB]);
  assign lnk.srcAddr = src_q;
  assign lnk.dstAddr = dst_q;
  assign lnk.bufferLength = len_q;
  assign lnk.shiftStep = step_q;
  assign lnk.memWe = memWe_q;
  assign lnk.memAddr = maddr_q;
  assign lnk.memWdata = mdata_q;

endmodule : wsf_host

// file: wsf_assertions.sv
// Link checker for the sequencer to engine handshake
`timescale 1ns/1ns
`include "wsf_cfg.svh"
module wsf_assertions (
  input logic clk,
  input logic nrst,
  input logic scan,
  input logic cond,
  input logic cont,
  input wsf_pkg::wsf_op_t op,
  input logic [`WSF_LEN_W-1:0] bufferLength,
  input logic [`WSF_LEN_W-1:0] shiftStep,
  input logic busy,
  input logic done,
  input logic carryFlag,
  input logic zeroFlag,
  input logic paramErr
);
  logic condSeen_q;
  logic trig;
  logic bad;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // History moves only on accepted scans
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      condSeen_q <= 1'b0;
    else if (scan && !busy)
      condSeen_q <= cond;
  end
  assign trig = scan && !busy && cond && (cont || !condSeen_q);
  assign bad = op[1] ? (bufferLength < `WSF_QUEUE_LEN_MIN || bufferLength > `WSF_LEN_MAX)
    : (bufferLength < `WSF_SHIFT_LEN_MIN || bufferLength > `WSF_LEN_MAX
    || shiftStep == 10'h000 || shiftStep > bufferLength);
  ////////////////////////////////////////
  property p_bad_param;
    trig && bad |=> done && paramErr && !busy;
  endproperty
  a_bad_param: assert property (p_bad_param)
    else $error("illegal parameters not refused");
  property p_good_start;
    trig && !bad |=> busy && !done;
  endproperty
  a_good_start: assert property (p_good_start)
    else $error("legal trigger did not start");
  property p_idle_scan;
    scan && !busy && !trig |=> !busy && !done;
  endproperty
  a_idle_scan: assert property (p_idle_scan)
    else $error("scan without edge started work");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_busy_end;
    $fell(busy) |-> done;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy fell without done");
  property p_busy_bound;
    $rose(busy) |-> ##[1:1000] !busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("operation too long");
  property p_carry_src;
    $changed(carryFlag) |-> $past(busy) && op == wsf_pkg::OP_QUEUE_WRITE;
  endproperty
  a_carry_src: assert property (p_carry_src)
    else $error("carry moved outside queue write");
  property p_zero_src;
    $changed(zeroFlag) |-> $past(busy) && op == wsf_pkg::OP_QUEUE_READ;
  endproperty
  a_zero_src: assert property (p_zero_src)
    else $error("zero moved outside queue read");
  property p_scan_gap;
    scan |=> !scan;
  endproperty
  a_scan_gap: assert property (p_scan_gap)
    else $error("scans in consecutive cycles");
endmodule : wsf_assertions

// file: word_shift_fifo_unit_tb.sv
// Testbench: APB sequencer driving the word-shift engine
`timescale 1ns/1ns
`include "wsf_cfg.svh"
`define CHK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module word_shift_fifo_unit_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`WSF_ABUS_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int failures = 0;
  int checked = 0;
  logic [31:0] rv;
  logic [31:0] iv;
  logic errSeen;
  logic irqSeen;
  wsf_if lnk ();
  wsf_device wsf_device_i (.clk(clk), .nrst(nrst), .lnk(lnk));
  wsf_host wsf_host_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .lnk(lnk));
  wsf_assertions wsf_assertions_i (.clk(clk), .nrst(nrst), .scan(lnk.scan), .cond(lnk.cond),
    .cont(lnk.cont), .op(lnk.op), .bufferLength(lnk.bufferLength), .shiftStep(lnk.shiftStep),
    .busy(lnk.busy), .done(lnk.done), .carryFlag(lnk.carryFlag), .zeroFlag(lnk.zeroFlag),
    .paramErr(lnk.paramErr));
  ////////////////////////////////////////
  task automatic report_and_stop();
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge clk);
    if (pready !== 1'b1)
    begin
      failures++;
      report_and_stop();
    end
    rv = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask : rd
  task automatic mw(input logic [9:0] a, input logic [15:0] d);
    wr(`WSF_REG_MADDR, {22'h000000, a});
    wr(`WSF_REG_MDATA, {16'h0000, d});
  endtask : mw
  task automatic mchk(input logic [9:0] a, input logic [15:0] ex);
    wr(`WSF_REG_MADDR, {22'h000000, a});
    rd(`WSF_REG_MDATA);
    `CHK("memory word", ex, rv[15:0])
  endtask : mchk
  task automatic cfg(input logic [9:0] s, input logic [9:0] d, input logic [9:0] l,
    input logic [9:0] st);
    // Word operands only, so digit counts always agree
    wr(`WSF_REG_SRC, {22'h000000, s});
    wr(`WSF_REG_DST, {22'h000000, d});
    wr(`WSF_REG_LEN, {22'h000000, l});
    wr(`WSF_REG_STEP, {22'h000000, st});
  endtask : cfg
  task automatic doScan(input wsf_pkg::wsf_op_t op, input logic k, input logic c);
    wr(`WSF_REG_CTRL, {28'h0000000, c, k, op});
    wr(`WSF_REG_SCAN, 32'h00000001);
  endtask : doScan
  // Pulse mode needs a low scan first to re-arm the edge
  task automatic run(input wsf_pkg::wsf_op_t op, input logic k);
    int n;
    if (!k)
      doScan(op, 1'b0, 1'b0);
    doScan(op, k, 1'b1);
    for (n = 0; n < 300; n++)
    begin
      rd(`WSF_REG_INTST);
      if (rv[`WSF_INT_DONE_BIT] === 1'b1)
        break;
    end
    if (rv[`WSF_INT_DONE_BIT] !== 1'b1)
    begin
      failures++;
      report_and_stop();
    end
    iv = rv;
    irqSeen = irq;
    wr(`WSF_REG_INTST, 32'h0000000F);
  endtask : run
  ////////////////////////////////////////
  task automatic t_regs();
    rd(`WSF_REG_STATUS);
    `CHK("status reset", 32'h00000000, rv)
    rd(8'h3C);
    `CHK("unmapped error", 1'b1, errSeen)
    `CHK("unmapped data", 32'h00000000, rv)
  endtask : t_regs
  task automatic t_shift();
    logic [15:0] ex [4] = '{16'h1001, 16'h1002, 16'h1003, 16'hA000};
    logic [15:0] ey [4] = '{16'hA000, 16'hA001, 16'h1001, 16'h1002};
    int i;
    for (i = 0; i < 4; i++)
      mw(10'h100 + 10'(i), 16'h1000 + 16'(i));
    mw(10'h200, 16'hA000);
    mw(10'h201, 16'hA001);
    cfg(10'h200, 10'h100, 10'h004, 10'h001);
    run(wsf_pkg::OP_WORD_SHIFT_RIGHT, 1'b0);
    for (i = 0; i < 4; i++)
      mchk(10'h100 + 10'(i), ex[i]);
    doScan(wsf_pkg::OP_WORD_SHIFT_RIGHT, 1'b0, 1'b1);
    // Long enough for a wrongly started shift to finish
    repeat (20) @(posedge clk);
    rd(`WSF_REG_INTST);
    `CHK("held condition done", 1'b0, rv[0])
    mchk(10'h100, 16'h1001);
    cfg(10'h200, 10'h100, 10'h004, 10'h002);
    run(wsf_pkg::OP_WORD_SHIFT_LEFT, 1'b0);
    for (i = 0; i < 4; i++)
      mchk(10'h100 + 10'(i), ey[i]);
  endtask : t_shift
  task automatic t_params();
    wsf_pkg::wsf_op_t ops [7] = '{wsf_pkg::OP_WORD_SHIFT_RIGHT, wsf_pkg::OP_WORD_SHIFT_RIGHT,
      wsf_pkg::OP_WORD_SHIFT_LEFT, wsf_pkg::OP_WORD_SHIFT_LEFT, wsf_pkg::OP_QUEUE_WRITE,
      wsf_pkg::OP_QUEUE_READ, wsf_pkg::OP_WORD_SHIFT_LEFT};
    logic [9:0] lens [7] = '{10'h000, 10'h201, 10'h004, 10'h004, 10'h001, 10'h201, 10'h200};
    logic [9:0] steps [7] = '{10'h001, 10'h001, 10'h005, 10'h000, 10'h001, 10'h001, 10'h200};
    int i;
    for (i = 0; i < 7; i++)
    begin
      cfg(10'h200, 10'h000, lens[i], steps[i]);
      run(ops[i], 1'b0);
      `CHK("error event", i < 6, iv[3])
      rd(`WSF_REG_STATUS);
      `CHK("error status", i < 6, rv[3])
    end
    mchk(10'h000, 16'hA000);
  endtask : t_params
  task automatic t_qwrite();
    int i;
    mw(10'h300, 16'h0000); // pointer cleared first
    mw(10'h304, 16'h5555);
    wr(`WSF_REG_INTMASK, 32'h00000002);
    cfg(10'h200, 10'h300, 10'h004, 10'h001);
    for (i = 0; i < 4; i++)
    begin
      mw(10'h200, 16'hC000 + 16'(i));
      run(wsf_pkg::OP_QUEUE_WRITE, 1'b0);
      `CHK("carry event", i == 3, iv[1])
      `CHK("masked irq", i == 3, irqSeen)
    end
    rd(`WSF_REG_STATUS);
    `CHK("carry status", 1'b1, rv[1])
    mchk(10'h300, 16'h0003);
    for (i = 0; i < 3; i++)
      mchk(10'h301 + 10'(i), 16'hC000 + 16'(i));
    mchk(10'h304, 16'h5555);
    `CHK("irq cleared", 1'b0, irq)
  endtask : t_qwrite
  task automatic t_qread();
    int i;
    cfg(10'h300, 10'h400, 10'h004, 10'h001);
    run(wsf_pkg::OP_QUEUE_READ, 1'b0);
    mchk(10'h400, 16'hC000);
    mchk(10'h300, 16'h0002);
    mchk(10'h301, 16'hC001);
    mchk(10'h302, 16'hC002);
    mchk(10'h303, 16'hC002);
    // Condition held high: one read per scan until the queue is empty; the third scan reads nothing
    for (i = 0; i < 3; i++)
    begin
      run(wsf_pkg::OP_QUEUE_READ, 1'b1);
      `CHK("zero event", i == 2, iv[2])
    end
    rd(`WSF_REG_STATUS);
    `CHK("zero status", 1'b1, rv[2])
    mchk(10'h400, 16'hC002);
    mchk(10'h300, 16'h0000);
  endtask : t_qread
  ////////////////////////////////////////
  initial
  begin
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_shift();
    t_params();
    t_qwrite();
    t_qread();
    report_and_stop();
  end
endmodule : word_shift_fifo_unit_tb
